// ### lcs_cell.sv
// Summary of operation
// R1: Two edge-triggered storage elements share one clock and one enable.
// R2: Each element picks rising or falling clock edge on its own.
// R3: Enable is active high, not invertible; unused enable counts as high.
// R4: Flip-flop loads data on active edge when enabled, otherwise holds.
// R5: Latch mode passes data at inactive clock level, holds at active.
// R6: One bit per element picks set or reset for boot, global, local.
// R7: Local preset/clear is active high and forces the configured value.
// R8: Set/reset choice and local input enable are per element.
// R9: Global net forces configured value at boot, reconfig or when active.
// R10: Global net comes from a pin, optionally inverted, or a node.
// R11: Each data input selects F, G, H output or direct input.
// R12: Each registered output selects element or any control input.
// R13: Four control inputs map freely onto four internal controls.
// R14: Memory mode turns controls into enable, write enable, two data.
// R15: Elements work as registers regardless of function generators.
module lcs_cell
   import lcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire lcs_cell_cfg_s cell_cfg,
   input wire lcs_elem_cfg_s [LCS_NUM_ELEM-1:0] elem_cfg,
   input wire logic reconfig_req,
   input wire logic cell_clock_pin,
   input wire logic global_pin,
   input wire logic global_node,
   input wire logic [LCS_NUM_CTRL-1:0] cell_control_inputs,
   input wire logic lut_f_out,
   input wire logic lut_g_out,
   input wire logic lut_h_out,
   output logic first_registered_out,
   output logic second_registered_out,
   output logic third_lut_input_zero,
   output logic third_lut_input_one,
   output logic third_lut_input_two,
   output logic ram_write_enable,
   output logic ram_write_data_low,
   output logic ram_data_or_top_addr,
   output logic ram_top_addr_mode,
   output logic ram_capture_enable,
   output logic cell_running
);

   // ==========================================================
   // Decoding helpers
   // ==========================================================
   function automatic logic pick_ctrl(
      input logic [1:0] sel,
      input logic [LCS_NUM_CTRL-1:0] ins
   );
      pick_ctrl = ins[sel];
   endfunction : pick_ctrl

   function automatic logic pick_data(
      input logic [1:0] sel,
      input logic f,
      input logic g,
      input logic h,
      input logic direct
   );
      case (sel)
         LCS_SRC_LUT_F: pick_data = f;
         LCS_SRC_LUT_G: pick_data = g;
         LCS_SRC_LUT_H: pick_data = h;
         default: pick_data = direct;
      endcase
   endfunction : pick_data

   // ==========================================================
   // Cell clock pin synchroniser
   // ==========================================================
   // The cell clock is a pin, so it is sampled on the system
   // clock; a change counts once the second and third stages
   // agree, which also rejects single-sample glitches.
   logic clk_meta_reg;
   logic clk_s2_reg;
   logic clk_s3_reg;
   logic clk_level_reg;
   logic clk_rise_reg;
   logic clk_fall_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clk_meta_reg <= LCS_RST_BIT;
         clk_s2_reg <= LCS_RST_BIT;
         clk_s3_reg <= LCS_RST_BIT;
      end else begin
         clk_meta_reg <= cell_clock_pin;
         clk_s2_reg <= clk_meta_reg;
         clk_s3_reg <= clk_s2_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clk_level_reg <= LCS_RST_BIT;
         clk_rise_reg <= LCS_RST_BIT;
         clk_fall_reg <= LCS_RST_BIT;
      end else begin
         clk_rise_reg <= LCS_RST_BIT;
         clk_fall_reg <= LCS_RST_BIT;
         if (clk_s2_reg == clk_s3_reg && clk_s3_reg != clk_level_reg) begin
            clk_level_reg <= clk_s3_reg;
            clk_rise_reg <= clk_s3_reg;
            clk_fall_reg <= !clk_s3_reg;
         end
      end
   end

   // ==========================================================
   // Global preset/clear source
   // ==========================================================
   logic gpin_meta_reg;
   logic gpin_s2_reg;
   logic gpin_s3_reg;
   logic gpin_level_reg;
   logic global_preset_clear;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gpin_meta_reg <= LCS_RST_BIT;
         gpin_s2_reg <= LCS_RST_BIT;
         gpin_s3_reg <= LCS_RST_BIT;
      end else begin
         gpin_meta_reg <= global_pin;
         gpin_s2_reg <= gpin_meta_reg;
         gpin_s3_reg <= gpin_s2_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gpin_level_reg <= LCS_RST_BIT;
      end else if (gpin_s2_reg == gpin_s3_reg) begin
         gpin_level_reg <= gpin_s3_reg;
      end
   end

   // The node path is on the system clock and needs no sampling.
   always_comb begin
      if (cell_cfg.global_from_node) begin
         global_preset_clear = global_node; // [R10]
      end else begin
         global_preset_clear = gpin_level_reg ^ cell_cfg.global_pin_invert; // [R10]
      end
   end

   // ==========================================================
   // Boot sequencer
   // ==========================================================
   // After reset or a reconfiguration request every element is
   // loaded with its configured value before running.
   lcs_boot_e boot_reg;
   lcs_boot_e boot_next;
   logic force_init;

   always_comb begin
      boot_next = boot_reg;
      case (boot_reg)
         LCS_ST_LOAD: boot_next = LCS_ST_RUN;
         LCS_ST_RUN: begin
            if (reconfig_req) begin
               boot_next = LCS_ST_LOAD;
            end
         end
         default: boot_next = LCS_ST_LOAD;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         boot_reg <= LCS_ST_LOAD;
      end else begin
         boot_reg <= boot_next;
      end
   end

   assign force_init = (boot_reg != LCS_ST_RUN) || global_preset_clear; // [R9]

   // ==========================================================
   // Control input mapping
   // ==========================================================
   lcs_ctrl_s ctrl;

   always_comb begin
      ctrl.capture_enable = pick_ctrl(cell_cfg.map_capture,
                                      cell_control_inputs); // [R13]
      ctrl.preset_or_lut_zero = pick_ctrl(cell_cfg.map_preset_lut_zero,
                                          cell_control_inputs); // [R13]
      ctrl.direct_or_lut_two = pick_ctrl(cell_cfg.map_direct_lut_two,
                                         cell_control_inputs); // [R13]
      ctrl.lut_one = pick_ctrl(cell_cfg.map_lut_one,
                               cell_control_inputs); // [R13]
   end

   // In memory mode the preset line is the write enable and no
   // longer reaches the storage elements.
   logic preset_to_elems;
   logic direct_to_elems;

   assign preset_to_elems = ctrl.preset_or_lut_zero && !cell_cfg.mem_mode;
   assign direct_to_elems = ctrl.direct_or_lut_two;

   // ==========================================================
   // Storage elements
   // ==========================================================
   logic [LCS_NUM_ELEM-1:0] elem_q;
   logic [LCS_NUM_ELEM-1:0] elem_edge;
   logic [LCS_NUM_ELEM-1:0] elem_inactive;
   logic [LCS_NUM_ELEM-1:0] elem_capture;
   logic [LCS_NUM_ELEM-1:0] elem_data;
   logic [LCS_NUM_ELEM-1:0] out_next;

   genvar gi;
   generate
      for (gi = 0; gi < LCS_NUM_ELEM; gi++) begin : g_elem
         // Both elements see the same clock and enable pins.
         assign elem_edge[gi] = elem_cfg[gi].invert_clk ?
                                clk_fall_reg : clk_rise_reg; // [R1] [R2]
         assign elem_inactive[gi] = elem_cfg[gi].invert_clk ?
                                    clk_level_reg : !clk_level_reg; // [R5]
         assign elem_capture[gi] = elem_cfg[gi].capture_used ?
                                   ctrl.capture_enable : LCS_ONE_BIT; // [R3]
         assign elem_data[gi] = pick_data(elem_cfg[gi].data_sel,
                                          lut_f_out, lut_g_out, lut_h_out,
                                          direct_to_elems); // [R11] [R15]
         assign out_next[gi] = elem_cfg[gi].bypass ?
                               pick_ctrl(elem_cfg[gi].bypass_sel,
                                         cell_control_inputs) :
                               elem_q[gi]; // [R12]

         lcs_store u_store (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .active_edge(elem_edge[gi]),
            .clock_inactive(elem_inactive[gi]),
            .capture_enable(elem_capture[gi]),
            .async_preset_clear(preset_to_elems),
            .force_init(force_init),
            .init_set(elem_cfg[gi].init_set),
            .preset_clear_enable(elem_cfg[gi].preset_clear_enable),
            .latch_mode(elem_cfg[gi].latch_mode),
            .data_in(elem_data[gi]),
            .q(elem_q[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Registered cell outputs
   // ==========================================================
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         first_registered_out <= LCS_RST_BIT;
         second_registered_out <= LCS_RST_BIT;
      end else begin
         first_registered_out <= out_next[0]; // [R12]
         second_registered_out <= out_next[1]; // [R12]
      end
   end

   // ==========================================================
   // Function generator and memory control outputs
   // ==========================================================
   // Logic mode drives the third function generator inputs;
   // memory mode drives the write port controls instead.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         third_lut_input_zero <= LCS_RST_BIT;
         third_lut_input_one <= LCS_RST_BIT;
         third_lut_input_two <= LCS_RST_BIT;
      end else if (cell_cfg.mem_mode) begin
         third_lut_input_zero <= LCS_RST_BIT;
         third_lut_input_one <= LCS_RST_BIT;
         third_lut_input_two <= LCS_RST_BIT;
      end else begin
         third_lut_input_zero <= ctrl.preset_or_lut_zero; // [R13]
         third_lut_input_one <= ctrl.lut_one; // [R13]
         third_lut_input_two <= ctrl.direct_or_lut_two; // [R13]
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ram_write_enable <= LCS_RST_BIT;
         ram_write_data_low <= LCS_RST_BIT;
         ram_data_or_top_addr <= LCS_RST_BIT;
         ram_top_addr_mode <= LCS_RST_BIT;
         ram_capture_enable <= LCS_RST_BIT;
      end else if (cell_cfg.mem_mode) begin
         ram_write_enable <= ctrl.preset_or_lut_zero; // [R14]
         ram_write_data_low <= ctrl.direct_or_lut_two; // [R14]
         ram_data_or_top_addr <= ctrl.lut_one; // [R14]
         ram_top_addr_mode <= cell_cfg.ram_wide; // [R14]
         ram_capture_enable <= ctrl.capture_enable; // [R14]
      end else begin
         ram_write_enable <= LCS_RST_BIT;
         ram_write_data_low <= LCS_RST_BIT;
         ram_data_or_top_addr <= LCS_RST_BIT;
         ram_top_addr_mode <= LCS_RST_BIT;
         ram_capture_enable <= LCS_RST_BIT;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cell_running <= LCS_RST_BIT;
      end else begin
         cell_running <= (boot_next == LCS_ST_RUN);
      end
   end

endmodule : lcs_cell

// ### lcs_pkg.sv
package lcs_pkg;

   // ==========================================================
   // Selector codes
   // ==========================================================
   localparam logic [1:0] LCS_SRC_LUT_F = 2'h0;
   localparam logic [1:0] LCS_SRC_LUT_G = 2'h1;
   localparam logic [1:0] LCS_SRC_LUT_H = 2'h2;
   localparam logic [1:0] LCS_SRC_DIRECT = 2'h3;

   // ==========================================================
   // Widths and reset values
   // ==========================================================
   localparam int LCS_NUM_CTRL = 4;
   localparam int LCS_NUM_ELEM = 2;
   localparam logic LCS_RST_BIT = 1'h0;
   localparam logic LCS_ONE_BIT = 1'h1;

   // ==========================================================
   // Configuration carriers
   // ==========================================================
   // Configuration of one storage element and its output selector.
   typedef struct packed {
      logic invert_clk;
      logic latch_mode;
      logic init_set;
      logic preset_clear_enable;
      logic capture_used;
      logic [1:0] data_sel;
      logic bypass;
      logic [1:0] bypass_sel;
   } lcs_elem_cfg_s;

   // Configuration shared by the whole cell.
   typedef struct packed {
      logic [1:0] map_capture;
      logic [1:0] map_preset_lut_zero;
      logic [1:0] map_direct_lut_two;
      logic [1:0] map_lut_one;
      logic mem_mode;
      logic ram_wide;
      logic global_from_node;
      logic global_pin_invert;
   } lcs_cell_cfg_s;

   // Internal control signals after the input mapping.
   typedef struct packed {
      logic capture_enable;
      logic preset_or_lut_zero;
      logic direct_or_lut_two;
      logic lut_one;
   } lcs_ctrl_s;

   // Boot sequencer states.
   typedef enum logic [1:0] {
      LCS_ST_LOAD = 2'h1,
      LCS_ST_RUN = 2'h2
   } lcs_boot_e;

endpackage : lcs_pkg

// ### lcs_store.sv
module lcs_store
   import lcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic active_edge,
   input wire logic clock_inactive,
   input wire logic capture_enable,
   input wire logic async_preset_clear,
   input wire logic force_init,
   input wire logic init_set,
   input wire logic preset_clear_enable,
   input wire logic latch_mode,
   input wire logic data_in,
   output logic q
);

   // ==========================================================
   // Storage element
   // ==========================================================
   // Global and local forcing beat clock, enable and data; the
   // hold case simply leaves the register untouched.
   logic q_reg;
   logic local_force;

   assign local_force = preset_clear_enable && async_preset_clear; // [R8]
   assign q = q_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q_reg <= LCS_RST_BIT;
      end else if (force_init) begin
         q_reg <= init_set; // [R9]
      end else if (local_force) begin
         q_reg <= init_set; // [R6] [R7]
      end else if (capture_enable) begin
         if (latch_mode) begin
            if (clock_inactive) begin
               q_reg <= data_in; // [R5]
            end
         end else if (active_edge) begin
            q_reg <= data_in; // [R4]
         end
      end
   end

endmodule : lcs_store

// ### lcs_cell_monitor.sv
module lcs_cell_monitor
   import lcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire lcs_cell_cfg_s cell_cfg,
   input wire lcs_elem_cfg_s [LCS_NUM_ELEM-1:0] elem_cfg,
   input wire logic reconfig_req,
   input wire logic global_node,
   input wire logic [LCS_NUM_CTRL-1:0] cell_control_inputs,
   input wire logic first_registered_out,
   input wire logic second_registered_out,
   input wire logic third_lut_input_zero,
   input wire logic third_lut_input_one,
   input wire logic ram_capture_enable,
   input wire logic cell_running
);
   // ==========================================================
   // Properties
   // ==========================================================
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   AST_BOOT_RUN: assert property ($rose(nrst) |=> cell_running)
      else $error("run state not entered after reset");
   AST_BOOT_VAL: assert property ($rose(nrst) && !elem_cfg[0].bypass
      |-> ##[2:3] first_registered_out == elem_cfg[0].init_set)
      else $error("boot value wrong");
   AST_RECONF: assert property (cell_running && reconfig_req
      ##1 !reconfig_req |-> !cell_running ##[1:3] cell_running)
      else $error("reconfiguration sequence wrong");
   AST_GLOBAL: assert property (cell_cfg.global_from_node
      && global_node && !elem_cfg[0].bypass && $stable(elem_cfg)
      |-> ##2 first_registered_out == elem_cfg[0].init_set)
      else $error("global force missed");
   AST_LOCAL: assert property (!cell_cfg.mem_mode
      && cell_control_inputs[cell_cfg.map_preset_lut_zero]
      && elem_cfg[0].preset_clear_enable && !elem_cfg[0].bypass
      && $stable(elem_cfg) && $stable(cell_cfg)
      |-> ##2 first_registered_out == elem_cfg[0].init_set)
      else $error("local force missed");
   AST_BYPASS: assert property (elem_cfg[1].bypass
      && $stable(elem_cfg) && $past(nrst) |-> second_registered_out
      == $past(cell_control_inputs[elem_cfg[1].bypass_sel]))
      else $error("bypass path wrong");
   AST_MAP_ONE: assert property (!cell_cfg.mem_mode
      && $stable(cell_cfg) && $past(nrst) |-> third_lut_input_one
      == $past(cell_control_inputs[cell_cfg.map_lut_one]))
      else $error("control map wrong");
   AST_MEM_ZERO: assert property (cell_cfg.mem_mode
      && $past(cell_cfg.mem_mode)
      |-> !third_lut_input_zero && !third_lut_input_one)
      else $error("function input active in memory mode");
   AST_MEM_CE: assert property (cell_cfg.mem_mode
      && $stable(cell_cfg) && $past(nrst) |-> ram_capture_enable
      == $past(cell_control_inputs[cell_cfg.map_capture]))
      else $error("memory enable map wrong");
endmodule : lcs_cell_monitor

bind lcs_cell lcs_cell_monitor u_lcs_cell_monitor (
   .clk_sys(clk_sys), .nrst(nrst), .cell_cfg(cell_cfg),
   .elem_cfg(elem_cfg), .reconfig_req(reconfig_req),
   .global_node(global_node), .cell_control_inputs(cell_control_inputs),
   .first_registered_out(first_registered_out),
   .second_registered_out(second_registered_out),
   .third_lut_input_zero(third_lut_input_zero),
   .third_lut_input_one(third_lut_input_one),
   .ram_capture_enable(ram_capture_enable), .cell_running(cell_running));

// ### lcs_user_model.sv
module lcs_user_model
   import lcs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic want_clk,
   input wire logic [2:0] want_lut,
   input wire logic want_gpin,
   input wire logic want_gnode,
   output logic cell_clock_pin,
   output logic lut_f_out,
   output logic lut_g_out,
   output logic lut_h_out,
   output logic global_pin,
   output logic global_node
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] hold_reg = 2'h0;

   initial begin
      cell_clock_pin = 1'h0;
   end

   // The cell clock keeps each level for at least three system cycles.
   always @(posedge clk_sys) begin
      if (hold_reg != 2'h0) begin
         hold_reg <= hold_reg - 2'h1;
      end else if (want_clk != cell_clock_pin) begin
         cell_clock_pin <= want_clk;
         hold_reg <= 2'h2;
      end
      {lut_h_out, lut_g_out, lut_f_out} <= want_lut;
      global_pin <= want_gpin;
      global_node <= want_gnode;
   end
endmodule : lcs_user_model

// ### lcs_cell_tb_top.sv
module lcs_cell_tb_top
   import lcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clk_sys = 1'h0;
   logic nrst = 1'h0;
   lcs_cell_cfg_s cc;
   lcs_elem_cfg_s [1:0] ec;
   logic [3:0] ctrl;
   logic [2:0] want_lut;
   logic reconfig_req, want_clk, want_gpin, want_gnode;
   logic cell_clock_pin, global_pin, global_node, lut_f, lut_g, lut_h;
   logic q0, q1, t0, t1, t2, rtam, rce, run, rwe, rwd, rta;
   int failures = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;

`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
   failures++; $display("BAD %s exp %0h got %0h", n, e, a); end end

   always #50 clk_sys = ~clk_sys;

   lcs_user_model u_lcs_user_model (.clk_sys(clk_sys),
      .want_clk(want_clk), .want_lut(want_lut), .want_gpin(want_gpin),
      .want_gnode(want_gnode), .cell_clock_pin(cell_clock_pin),
      .lut_f_out(lut_f), .lut_g_out(lut_g), .lut_h_out(lut_h),
      .global_pin(global_pin), .global_node(global_node));

   lcs_cell u_lcs_cell (.clk_sys(clk_sys), .nrst(nrst), .cell_cfg(cc),
      .elem_cfg(ec), .reconfig_req(reconfig_req),
      .cell_clock_pin(cell_clock_pin), .global_pin(global_pin),
      .global_node(global_node), .cell_control_inputs(ctrl),
      .lut_f_out(lut_f), .lut_g_out(lut_g), .lut_h_out(lut_h),
      .first_registered_out(q0), .second_registered_out(q1),
      .third_lut_input_zero(t0), .third_lut_input_one(t1),
      .third_lut_input_two(t2), .ram_write_enable(rwe),
      .ram_write_data_low(rwd), .ram_data_or_top_addr(rta),
      .ram_top_addr_mode(rtam), .ram_capture_enable(rce),
      .cell_running(run));

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt

   task automatic pulse();
      want_clk = 1'h1;
      wt(10);
      want_clk = 1'h0;
      wt(10);
   endtask : pulse

   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic t_flop();
      for (int s = 0; s < 3; s++) begin
         ec[0].data_sel = 2'(s);
         want_lut = 3'(1 << s);
         ctrl[2] = 1'h1;
         want_clk = 1'h1;
         wt(10);
         `CHK("rise q0", 1'h1, q0)
         `CHK("rise q1", 1'h0, q1)
         want_clk = 1'h0;
         wt(10);
         `CHK("fall q1", 1'h1, q1)
         want_lut = ~3'(1 << s);
         ctrl[2] = 1'h0;
         pulse();
         `CHK("sel q0", 1'h0, q0)
         `CHK("sel q1", 1'h0, q1)
      end
      $display("end flop");
   endtask : t_flop

   task automatic t_enable();
      ec[0].capture_used = 1'h1;
      ctrl = 4'h4;
      want_lut = 3'h1;
      ec[0].data_sel = LCS_SRC_LUT_F;
      pulse();
      `CHK("ce hold", 1'h0, q0)
      `CHK("ce unused", 1'h1, q1)
      ctrl[0] = 1'h1;
      pulse();
      `CHK("ce load", 1'h1, q0)
      ec[0].capture_used = 1'h0;
      ctrl = 4'h0;
      pulse();
      $display("end enable");
   endtask : t_enable

   task automatic t_latch();
      ec[0].latch_mode = 1'h1;
      want_lut = 3'h0;
      wt(6);
      `CHK("latch pass0", 1'h0, q0)
      want_lut = 3'h1;
      wt(6);
      `CHK("latch pass1", 1'h1, q0)
      want_clk = 1'h1;
      wt(10);
      want_lut = 3'h0;
      wt(6);
      `CHK("latch hold", 1'h1, q0)
      want_clk = 1'h0;
      wt(10);
      `CHK("latch reopen", 1'h0, q0)
      ec[0].latch_mode = 1'h0;
      $display("end latch");
   endtask : t_latch

   task automatic t_local();
      ec[0].preset_clear_enable = 1'h1;
      ec[1].init_set = 1'h1;
      ctrl = 4'h2;
      wt(4);
      `CHK("local q0", 1'h1, q0)
      `CHK("local q1", 1'h0, q1)
      ctrl[2] = 1'h1;
      pulse();
      `CHK("local over clock", 1'h1, q0)
      `CHK("local off", 1'h1, q1)
      ctrl = 4'h0;
      ec[0].preset_clear_enable = 1'h0;
      ec[1].init_set = 1'h0;
      $display("end local");
   endtask : t_local

   task automatic t_bypass();
      ec[0].bypass = 1'h1;
      ec[1].bypass = 1'h1;
      for (int i = 0; i < 4; i++) begin
         ec[0].bypass_sel = 2'(i);
         ec[1].bypass_sel = 2'(3 - i);
         ctrl = 4'(1 << i);
         wt(3);
         `CHK("bypass q0", 1'h1, q0)
         `CHK("bypass q1", ctrl[3 - i], q1)
      end
      ec[0].bypass = 1'h0;
      ec[1].bypass = 1'h0;
      ctrl = 4'h0;
      $display("end bypass");
   endtask : t_bypass

   task automatic t_map();
      for (int i = 0; i < 4; i++) begin
         cc.map_lut_one = 2'(i);
         cc.map_direct_lut_two = 2'(i);
         ctrl = 4'(1 << i);
         wt(3);
         `CHK("map one", 1'h1, t1)
         `CHK("map two", 1'h1, t2)
         `CHK("map zero", 1'(i == 1), t0)
         `CHK("map no we", 1'h0, rwe)
         cc.mem_mode = 1'h1;
         cc.ram_wide = 1'(i);
         cc.map_capture = 2'(i);
         wt(3);
         `CHK("mem ce", 1'h1, rce)
         `CHK("mem off", 1'h0, t1)
         `CHK("mem wide", 1'(i), rtam)
         `CHK("mem we", 1'(i == 1), rwe)
         `CHK("mem d0", 1'h1, rwd)
         `CHK("mem d1", 1'h1, rta)
         cc.mem_mode = 1'h0;
      end
      cc.map_capture = 2'h0;
      cc.map_direct_lut_two = 2'h2;
      cc.map_lut_one = 2'h3;
      ctrl = 4'h4;
      want_lut = 3'h0;
      pulse();
      $display("end map");
   endtask : t_map

   task automatic t_global();
      want_gnode = 1'h1;
      wt(1);
      want_gnode = 1'h0;
      wt(6);
      `CHK("node q0", 1'h1, q0)
      `CHK("node q1", 1'h0, q1)
      want_gpin = 1'h1;
      wt(6);
      cc.global_pin_invert = 1'h1;
      cc.global_from_node = 1'h0;
      pulse();
      `CHK("pin idle", 1'h1, q1)
      want_gpin = 1'h0;
      wt(4);
      want_gpin = 1'h1;
      wt(10);
      `CHK("pin q0", 1'h1, q0)
      `CHK("pin q1", 1'h0, q1)
      cc.global_from_node = 1'h1;
      cc.global_pin_invert = 1'h0;
      want_gpin = 1'h0;
      pulse();
      reconfig_req = 1'h1;
      wt(1);
      reconfig_req = 1'h0;
      `CHK("reconf load", 1'h0, run)
      wt(4);
      `CHK("reconf run", 1'h1, run)
      `CHK("reconf q0", 1'h1, q0)
      `CHK("reconf q1", 1'h0, q1)
      $display("end global");
   endtask : t_global

   // ==========================================================
   // Sequence
   // ==========================================================
   always @(posedge clk_sys) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      cc = '0;
      cc.map_preset_lut_zero = 2'h1;
      cc.map_direct_lut_two = 2'h2;
      cc.map_lut_one = 2'h3;
      cc.global_from_node = 1'h1;
      ec = '0;
      ec[0].init_set = 1'h1;
      ec[1].invert_clk = 1'h1;
      ec[1].data_sel = LCS_SRC_DIRECT;
      {ctrl, want_lut, reconfig_req} = '0;
      {want_clk, want_gpin, want_gnode} = '0;
      wt(12);
      nrst = 1'h1;
      wt(4);
      `CHK("boot run", 1'h1, run)
      `CHK("boot q0", 1'h1, q0)
      `CHK("boot q1", 1'h0, q1)
      $display("end boot");
      t_flop();
      t_enable();
      t_latch();
      t_local();
      t_bypass();
      t_map();
      t_global();
      stop_test();
   end
endmodule : lcs_cell_tb_top
